/* pfc_defs.svh */
// Purpose: Constants for the parallel flash command controller
// Assumes: 25 MHz clk, 40 ns period
// Notes:   Offsets are byte addresses on the Avalon-MM slave
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH
// Register byte offsets (word aligned)
`define PFC_REG_CTRL      4'h0
`define PFC_REG_ADDR      4'h4
`define PFC_REG_WDATA     4'h8
`define PFC_REG_STATUS    4'hC
// Control fields
`define PFC_CTRL_GO_BIT   0
`define PFC_CTRL_CMD_LSB  4
`define PFC_CTRL_CMD_W    3
// Status fields
`define PFC_ST_BUSY_BIT   0
`define PFC_ST_RDY_BIT    1
`define PFC_ST_TOUT_BIT   2
`define PFC_ST_DATA_LSB   8
// Unlock codes
`define PFC_UNLOCK_A1     20'h05555
`define PFC_UNLOCK_A2     20'h02AAA
`define PFC_UNLOCK_D1     8'hAA
`define PFC_UNLOCK_D2     8'h55
`define PFC_CODE_ERASE1   8'h80
`define PFC_CODE_CHIP     8'h10
`define PFC_CODE_LOCK     8'h40
`define PFC_CODE_PROG     8'hA0
`define PFC_CODE_IDIN     8'h90
`define PFC_CODE_IDOUT    8'hF0
`define PFC_ADDR_LOCKST   20'h00002
`define PFC_BOOT_LAST     20'h03FFF
// Bus cycle timing, in clk cycles
`define PFC_SETUP_CYC     4'd2
`define PFC_STROBE_CYC    4'd4
`define PFC_HOLD_CYC      4'd2
`define PFC_RESET_VAL     32'h00000000
`endif

/* pfc_pkg.sv */
// Purpose: Types for the parallel flash command controller
// Assumes: pfc_defs.svh holds the numbers
// Notes:   One-hot state codes
package pfc_pkg;
  typedef enum logic [2:0] {
    PFC_OP_READ  = 3'h0,
    PFC_OP_PROG  = 3'h1,
    PFC_OP_CHIP  = 3'h2,
    PFC_OP_LOCK  = 3'h3,
    PFC_OP_IDIN  = 3'h4,
    PFC_OP_IDOUT = 3'h5,
    PFC_OP_IDX1  = 3'h6
  } pfc_op_t;
  typedef enum logic [5:0] {
    PFC_IDLE  = 6'h01,
    PFC_SETUP = 6'h02,
    PFC_STRB  = 6'h04,
    PFC_HOLD  = 6'h08,
    PFC_WAIT  = 6'h10,
    PFC_DONE  = 6'h20
  } pfc_state_t;
endpackage

/* pfc_sync.sv */
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Input is asynchronous to clk
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module pfc_sync
#(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_dout;

  // Shift pin level through two stages
  always_comb
  begin
    next_stage1 = din;
    next_dout   = stage1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1 <= '0;
      dout   <= '0;
    end
    else
    begin
      stage1 <= next_stage1;
      dout   <= next_dout;
    end
  end
endmodule
`default_nettype wire

/* pfc_ctrl.sv */
// Purpose: Host-side controller driving a byte-wide parallel flash
// Assumes: 25 MHz clk; software on Avalon-MM issues one command at a time
// Notes:   Status poll of the busy pin ends program and erase
//
// Operation
// - Chip erase issues six unlock writes ending 5555/10 in order.
// - Byte program issues three unlock writes then target address and data.
// - Boot lockout issues six unlock writes ending 5555/40.
// - Identification entry ends 5555/90; exit via sequence or single F0.
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "pfc_defs.svh"
module pfc_ctrl
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [1:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output var  logic [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output var  logic [19:0] flash_addr,
  input  wire logic [7:0]  flash_data_in,
  output var  logic [7:0]  flash_data_out,
  output var  logic        flash_data_oe_n,
  output var  logic        flash_ce_n,
  output var  logic        flash_oe_n,
  output var  logic        flash_we_n,
  output var  logic        flash_reset_n,
  input  wire logic        flash_ready
);
  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [7:0] data_s;
  logic       ready_s;

  pfc_sync #(.W(9)) u_sync
  (
    .clk    (clk),
    .resetn (resetn),
    .din    ({flash_ready, flash_data_in}),
    .dout   ({ready_s, data_s})
  );

  ////////////////////////////////////////////////////////////////
  // State
  pfc_pkg::pfc_state_t state, next_state;
  pfc_pkg::pfc_op_t    op, next_op;
  logic [2:0]  step, next_step;
  logic [3:0]  cnt, next_cnt;
  logic [19:0] addr_reg, next_addr_reg;
  logic [7:0]  wdata_reg, next_wdata_reg;
  logic [7:0]  rdata, next_rdata;
  logic        is_read, next_is_read;
  logic        rst_pin, next_rst_pin;
  logic [19:0] cyc_addr;
  logic [7:0]  cyc_data;
  logic [2:0]  nsteps;
  logic        go;

  assign go = avs_write && (avs_address == 2'(`PFC_REG_CTRL >> 2))
              && avs_writedata[`PFC_CTRL_GO_BIT];

  // Steps per command
  always_comb
  begin
    case (op)
      pfc_pkg::PFC_OP_PROG:  nsteps = 3'd4;
      pfc_pkg::PFC_OP_CHIP:  nsteps = 3'd6;
      pfc_pkg::PFC_OP_LOCK:  nsteps = 3'd6;
      pfc_pkg::PFC_OP_IDIN:  nsteps = 3'd3;
      pfc_pkg::PFC_OP_IDOUT: nsteps = 3'd3;
      pfc_pkg::PFC_OP_IDX1:  nsteps = 3'd1;
      default:               nsteps = 3'd1;
    endcase
  end

  // Address and data of the current bus cycle; read and PFC_OP_IDX1 use one cycle at addr_reg
  always_comb
  begin
    cyc_addr = `PFC_UNLOCK_A1;
    cyc_data = `PFC_UNLOCK_D1;
    if (op == pfc_pkg::PFC_OP_READ)
    begin
      cyc_addr = addr_reg;
      cyc_data = 8'h00;
    end
    else if (op == pfc_pkg::PFC_OP_IDX1)
    begin
      cyc_addr = addr_reg;
      cyc_data = `PFC_CODE_IDOUT;
    end
    else if (op == pfc_pkg::PFC_OP_PROG && step == 3'd3)
    begin
      cyc_addr = addr_reg;
      cyc_data = wdata_reg;
    end
    else
    begin
      case (step)
        3'd0, 3'd3: cyc_data = `PFC_UNLOCK_D1;
        3'd1, 3'd4:
        begin
          cyc_addr = `PFC_UNLOCK_A2;
          cyc_data = `PFC_UNLOCK_D2;
        end
        3'd2:
        begin
          case (op)
            pfc_pkg::PFC_OP_PROG:  cyc_data = `PFC_CODE_PROG;
            pfc_pkg::PFC_OP_IDIN:  cyc_data = `PFC_CODE_IDIN;
            pfc_pkg::PFC_OP_IDOUT: cyc_data = `PFC_CODE_IDOUT;
            default:               cyc_data = `PFC_CODE_ERASE1;
          endcase
        end
        default:  // Final step of six-cycle codes
        begin
          cyc_data = (op == pfc_pkg::PFC_OP_CHIP) ? `PFC_CODE_CHIP : `PFC_CODE_LOCK;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb
  begin
    next_state     = state;
    next_op        = op;
    next_step      = step;
    next_cnt       = cnt;
    next_addr_reg  = addr_reg;
    next_wdata_reg = wdata_reg;
    next_rdata     = rdata;
    next_is_read   = is_read;
    next_rst_pin   = rst_pin;
    if (avs_write && state == pfc_pkg::PFC_IDLE)
    begin
      if (avs_address == 2'(`PFC_REG_ADDR >> 2))
        next_addr_reg = avs_writedata[19:0];
      if (avs_address == 2'(`PFC_REG_WDATA >> 2))
        next_wdata_reg = avs_writedata[7:0];
      if (avs_address == 2'(`PFC_REG_CTRL >> 2))
        next_rst_pin = ~avs_writedata[1];  // Bit 1 holds flash in reset
    end
    case (state)
      pfc_pkg::PFC_IDLE:
      begin
        if (go && rst_pin)
        begin
          next_op    = pfc_pkg::pfc_op_t'(avs_writedata[`PFC_CTRL_CMD_LSB +: `PFC_CTRL_CMD_W]);
          next_is_read = (avs_writedata[`PFC_CTRL_CMD_LSB +: `PFC_CTRL_CMD_W] == 3'h0);
          next_step  = 3'd0;
          next_cnt   = `PFC_SETUP_CYC;
          next_state = pfc_pkg::PFC_SETUP;
        end
      end
      pfc_pkg::PFC_SETUP:  // Address settles before strobe
      begin
        next_cnt = cnt - 4'd1;
        if (cnt == 4'd1)
        begin
          next_cnt   = `PFC_STROBE_CYC;
          next_state = pfc_pkg::PFC_STRB;
        end
      end
      pfc_pkg::PFC_STRB:
      begin
        next_cnt = cnt - 4'd1;
        if (cnt == 4'd1)
        begin
          next_rdata = data_s;
          next_cnt   = `PFC_HOLD_CYC;
          next_state = pfc_pkg::PFC_HOLD;
        end
      end
      pfc_pkg::PFC_HOLD:  // Data held past strobe rise
      begin
        next_cnt = cnt - 4'd1;
        if (cnt == 4'd1)
        begin
          if (!is_read && step != nsteps - 3'd1)
          begin
            next_step  = step + 3'd1;
            next_cnt   = `PFC_SETUP_CYC;
            next_state = pfc_pkg::PFC_SETUP;
          end
          else if (op == pfc_pkg::PFC_OP_PROG || op == pfc_pkg::PFC_OP_CHIP)
            next_state = pfc_pkg::PFC_WAIT;
          else
            next_state = pfc_pkg::PFC_DONE;
        end
      end
      pfc_pkg::PFC_WAIT:  // Flash times itself; busy pin released at end
      begin
        if (ready_s)
          next_state = pfc_pkg::PFC_DONE;
      end
      pfc_pkg::PFC_DONE: next_state = pfc_pkg::PFC_IDLE;
      default:           next_state = pfc_pkg::PFC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state     <= pfc_pkg::PFC_IDLE;
      op        <= pfc_pkg::PFC_OP_READ;
      step      <= 3'd0;
      cnt       <= 4'd0;
      addr_reg  <= 20'h00000;
      wdata_reg <= 8'h00;
      rdata     <= 8'h00;
      is_read   <= 1'b0;
      rst_pin   <= 1'b1;
    end
    else
    begin
      state     <= next_state;
      op        <= next_op;
      step      <= next_step;
      cnt       <= next_cnt;
      addr_reg  <= next_addr_reg;
      wdata_reg <= next_wdata_reg;
      rdata     <= next_rdata;
      is_read   <= next_is_read;
      rst_pin   <= next_rst_pin;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Pin drive, registered
  logic [19:0] next_flash_addr;
  logic [7:0]  next_flash_data_out;
  logic        next_data_oe_n, next_ce_n, next_oe_n, next_we_n;

  always_comb
  begin
    next_flash_addr     = flash_addr;
    next_flash_data_out = flash_data_out;
    next_data_oe_n      = 1'b1;
    next_ce_n           = 1'b1;
    next_oe_n           = 1'b1;
    next_we_n           = 1'b1;
    if (next_state == pfc_pkg::PFC_SETUP || next_state == pfc_pkg::PFC_STRB
        || next_state == pfc_pkg::PFC_HOLD)
    begin
      next_flash_addr     = (next_state == pfc_pkg::PFC_SETUP) ? cyc_addr : flash_addr;
      next_flash_data_out = (next_state == pfc_pkg::PFC_SETUP) ? cyc_data : flash_data_out;
      next_ce_n           = 1'b0;
      if (next_is_read)
        next_oe_n = (next_state == pfc_pkg::PFC_HOLD);  // Host never drives on read
      else
      begin
        next_data_oe_n = 1'b0;
        next_we_n      = (next_state != pfc_pkg::PFC_STRB);  // OE high during strobe
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      flash_addr      <= 20'h00000;
      flash_data_out  <= 8'h00;
      flash_data_oe_n <= 1'b1;
      flash_ce_n      <= 1'b1;
      flash_oe_n      <= 1'b1;
      flash_we_n      <= 1'b1;
      flash_reset_n   <= 1'b0;
    end
    else
    begin
      flash_addr      <= next_flash_addr;
      flash_data_out  <= next_flash_data_out;
      flash_data_oe_n <= next_data_oe_n;
      flash_ce_n      <= next_ce_n;
      flash_oe_n      <= next_oe_n;
      flash_we_n      <= next_we_n;
      flash_reset_n   <= rst_pin;  // Pin follows control bit
    end
  end

  ////////////////////////////////////////////////////////////////
  // Avalon slave: writes only in idle; reads take one wait state
  logic [31:0] next_readdata;
  logic        busy;
  logic        rd_ack, next_rd_ack;

  assign busy = (state != pfc_pkg::PFC_IDLE);
  // Read data is registered, so a read stalls one cycle until it stands
  assign avs_waitrequest = (avs_write && busy) || (avs_read && !rd_ack);

  always_comb
  begin
    next_rd_ack   = avs_read && !rd_ack;
    next_readdata = 32'h00000000;
    case (avs_address)
      2'(`PFC_REG_CTRL >> 2):  next_readdata = {30'h0, ~rst_pin, 1'b0};
      2'(`PFC_REG_ADDR >> 2):  next_readdata = {12'h000, addr_reg};
      2'(`PFC_REG_WDATA >> 2): next_readdata = {24'h000000, wdata_reg};
      default:
      begin
        next_readdata[`PFC_ST_BUSY_BIT] = busy;
        next_readdata[`PFC_ST_RDY_BIT]  = ready_s;
        next_readdata[`PFC_ST_DATA_LSB +: 8] = rdata;  // Polling bits 7 and 6
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      avs_readdata <= `PFC_RESET_VAL;
      rd_ack       <= 1'b0;
    end
    else
    begin
      avs_readdata <= next_readdata;
      rd_ack       <= next_rd_ack;
    end
  end
endmodule
`default_nettype wire

/* pfc_ctrl_asserts.sv */
// Purpose: Pin and bus checks for pfc_ctrl
// Assumes: One clk domain
// Notes:   Bound to every pfc_ctrl
`timescale 1ns/1ps
`default_nettype none
module pfc_ctrl_chk
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [19:0] flash_addr,
  input wire logic [7:0]  flash_data_out,
  input wire logic        flash_data_oe_n,
  input wire logic        flash_ce_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_we_n,
  input wire logic        flash_reset_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Steps of one flash cycle
  sequence s_we_pulse;
    (!flash_we_n)[*4] ##1 flash_we_n;
  endsequence
  sequence s_ce_hold;
    (!flash_ce_n)[*2];
  endsequence
  ////////////////////////////////////////
  a_rd_wr_excl: assert property (flash_we_n || flash_oe_n)
    else $error("read and write strobes low together");
  a_we_needs_ce: assert property (!flash_we_n |-> !flash_ce_n && !flash_data_oe_n)
    else $error("write strobe without select or data");
  a_no_clash: assert property (!flash_data_oe_n |-> flash_oe_n)
    else $error("host drives while flash outputs on");
  a_wr_stable: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr) && $stable(flash_data_out))
    else $error("address or data moved in strobe");
  a_we_width: assert property ($fell(flash_we_n) |-> s_we_pulse)
    else $error("write strobe width wrong");
  a_we_setup: assert property ($fell(flash_we_n) |-> !$past(flash_ce_n, 2))
    else $error("select not set up before strobe");
  a_we_hold: assert property ($rose(flash_we_n) |-> s_ce_hold)
    else $error("select released too early");
  a_oe_width: assert property ($fell(flash_oe_n) |-> (!flash_oe_n)[*6] ##1 flash_oe_n)
    else $error("read strobe width wrong");
  a_no_wr_reset: assert property (!flash_reset_n |-> flash_we_n)
    else $error("write to flash in reset");
  a_wait_write: assert property (avs_waitrequest |-> avs_write || avs_read)
    else $error("waitrequest without request");
endmodule
bind pfc_ctrl pfc_ctrl_chk chk_u (.clk, .resetn, .avs_read, .avs_write, .avs_waitrequest, .flash_addr, .flash_data_out,
  .flash_data_oe_n, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n);
`default_nettype wire

/* pfc_flash_model.sv */
// Purpose: Behavioural byte-wide flash
// Assumes: Pins sampled on falling osc edges
// Notes:   Array changes at command time
`timescale 1ns/1ps
`default_nettype none
module pfc_flash_model
#(
  parameter logic [7:0] MFG = 8'h5B, // Arbitrary value
  parameter logic [7:0] DEV = 8'h6C, // Arbitrary value
  parameter int         PT  = 40
)
(
  input  wire logic        osc,
  input  wire logic        slow,
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  din,
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        rst_n,
  output var  logic [7:0]  dout,
  output logic             dout_en,
  output logic             busy_n
);
  logic [7:0]  mem[logic [19:0]];
  logic [19:0] la;
  logic [7:0]  ld, pd;
  logic        wv, idm, oe_q = 1'b1, lock = 1'b0, tog = 1'b0;
  int          step, cnt;
  function automatic logic [7:0] rd(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF; // Erased
  endfunction
  function automatic logic prot(input logic [19:0] a);
    return lock && a <= 20'h03FFF;
  endfunction
  ////////////////////////////////////////
  // Plain read only; floats in reset
  assign dout_en = !ce_n && !oe_n && we_n && rst_n;
  assign busy_n = (cnt == 0);
  // Own timer and decoder; falling edge keeps clear of host sampling
  always @(negedge osc or negedge rst_n)
    if (!rst_n)
    begin
      cnt = 0;
      step = 0;
      wv = 0;
      idm = 0;
    end
    else
    begin
      if (cnt > 0) cnt--;
      if (!oe_n && oe_q && cnt > 0) tog = ~tog;
      if (!we_n && !ce_n && oe_n)
      begin
        la = addr;
        ld = din;
        wv = 1;
      end
      else if (wv)
      begin
        wv = 0;
        if (cnt != 0)
          step = 0;
        else if (ld == 8'hF0 && step != 6)
        begin
          idm = 0;
          step = 0;
        end
        else case (step)
          0, 3: step = (la == 20'h05555 && ld == 8'hAA) ? step + 1 : 0;
          1, 4: step = (la == 20'h02AAA && ld == 8'h55) ? step + 1 : 0;
          2:
          begin
            idm |= la == 20'h05555 && ld == 8'h90;
            step = la != 20'h05555 ? 0 : ld == 8'hA0 ? 6 : ld == 8'h80 ? 3 : 0;
          end
          5:
          begin
            lock |= la == 20'h05555 && ld == 8'h40;
            if (la == 20'h05555 && ld == 8'h10)
            begin
              foreach (mem[k])
                if (!prot(k)) mem[k] = 8'hFF;
              cnt = slow ? 16 * PT : 4 * PT;
              pd = 8'hFF;
            end
            step = 0;
          end
          default:
          begin
            if (!prot(la)) mem[la] = rd(la) & ld;
            pd = ld;
            cnt = slow ? 4 * PT : PT;
            step = 0;
          end
        endcase
      end
      oe_q = oe_n;
      dout = cnt != 0 ? {~pd[7], tog, pd[5:0]} : !idm ? rd(addr) : addr == 20'h0 ? MFG :
        addr == 20'h1 ? DEV : {7'h0, addr == 20'h2 && lock};
    end
endmodule
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench for pfc_ctrl
// Assumes: Avalon master tasks, flash model on pins
// Notes:   Row table first, reset cases after
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] MFG = 8'h5B; // Arbitrary value
  localparam logic [7:0] DEV = 8'h6C; // Arbitrary value
  typedef struct {logic [2:0] c; logic [19:0] a; logic [7:0] d; logic [19:0] ra; logic [7:0] x;} pfc_row_t;
  logic        clk = 1'b0, resetn = 1'b0, slow = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [1:0]  avs_address = 2'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rdv;
  logic        avs_waitrequest, flash_data_oe_n, flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n, fm_en, fm_busy_n;
  logic [19:0] flash_addr;
  logic [7:0]  flash_data_out, fm_dout;
  wire  [7:0]  flash_data_in = !flash_data_oe_n ? flash_data_out : fm_en ? fm_dout : ~fm_dout;
  wire         flash_ready = fm_busy_n; // Model drives the busy line directly
  int          n_mismatch = 0, n_tests = 0;
  pfc_row_t    rows[15] = '{'{3'h1, 20'h00100, 8'h5A, 20'h00100, 8'h5A}, '{3'h1, 20'h00100, 8'hA5, 20'h00100, 8'h00},
    '{3'h1, 20'h00010, 8'h33, 20'h00010, 8'h33}, '{3'h4, 20'h0, 8'h0, 20'h00000, MFG},
    '{3'h0, 20'h0, 8'h0, 20'h00001, DEV}, '{3'h0, 20'h0, 8'h0, 20'h00002, 8'h00},
    '{3'h5, 20'h0, 8'h0, 20'h00010, 8'h33}, '{3'h3, 20'h0, 8'h0, 20'h00010, 8'h33},
    '{3'h4, 20'h0, 8'h0, 20'h00002, 8'h01}, '{3'h6, 20'h12345, 8'h0, 20'h00010, 8'h33},
    '{3'h1, 20'h00010, 8'h00, 20'h00010, 8'h33}, '{3'h1, 20'h03FFF, 8'h00, 20'h03FFF, 8'hFF},
    '{3'h1, 20'h04000, 8'h0F, 20'h04000, 8'h0F}, '{3'h2, 20'h0, 8'h0, 20'h00010, 8'h33},
    '{3'h0, 20'h0, 8'h0, 20'h04000, 8'hFF}};
  pfc_ctrl dut_u (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .flash_addr, .flash_data_in, .flash_data_out, .flash_data_oe_n, .flash_ce_n, .flash_oe_n, .flash_we_n,
    .flash_reset_n, .flash_ready);
  pfc_flash_model #(.MFG(MFG), .DEV(DEV)) fm_u (.osc(clk), .slow(slow), .addr(flash_addr), .din(flash_data_in),
    .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .rst_n(flash_reset_n), .dout(fm_dout),
    .dout_en(fm_en), .busy_n(fm_busy_n));
  always #20 clk = ~clk;
  ////////////////////////////////////////
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Write held until waitrequest low, then one idle edge
  task automatic bw(input logic [1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000)
      n_mismatch++;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  // Read held until waitrequest low; data taken at that same edge
  task automatic br(input logic [1:0] a);
    int n;
    n = 0;
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 4000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 4000)
      n_mismatch++;
    rdv = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic op(input logic [2:0] c, input logic [19:0] a, input logic [7:0] d);
    int n;
    n = 0;
    bw(2'h1, {12'h000, a});
    bw(2'h2, {24'h000000, d});
    bw(2'h0, {25'h0, c, 4'h1});
    do
    begin
      br(2'h3);
      n++;
    end
    while (rdv[0] !== 1'b0 && n < 500);
    if (n >= 500)
      n_mismatch++;
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (rows[i])
    begin
      op(rows[i].c, rows[i].a, rows[i].d);
      op(3'h0, rows[i].ra, 8'h00);
      cmp(rdv[15:8], rows[i].x);
    end
    // Slow program, then reset while the flash is busy
    slow <= 1'b1;
    bw(2'h1, 32'h00004001);
    bw(2'h2, 32'h00000000);
    bw(2'h0, 32'h00000011);
    repeat (60) @(posedge clk);
    br(2'h3);
    cmp({7'h0, rdv[0]}, 8'h01);
    cmp({7'h0, flash_ready}, 8'h00);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    cmp({flash_reset_n, flash_we_n, flash_oe_n, flash_ce_n, flash_data_oe_n, flash_ready, 2'h0}, 8'h7C);
    cmp(avs_readdata[7:0], 8'h00);
    resetn <= 1'b1;
    @(posedge clk);
    slow <= 1'b0;
    op(3'h0, 20'h00010, 8'h00);
    cmp(rdv[15:8], 8'h33);
    final_report;
  end
  // Cuts a hang well past the expected run length
  initial
  begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    final_report;
  end
endmodule
`default_nettype wire
